// File: rtl/dip_pkg.sv
// Constants and register map for the DAC input port and serial control block
// Contract
// - Select low lets serial clock shift data
// - Select high ignores clock, output floats
// - Input bits captured on rising clock edge
// - Output bits launched on falling clock edge
// - Port A used only in dual mode
// - Samples are signed two's complement codes
// - Single mode takes samples from port B
// - Dual mode outputs A then B next cycle
// - Divided clock rate and drive from clock_output_config
// - Zero code is mid-scale current split
// - Power-down while power_down_n is low
// - Test outputs steered by test_output_control_a and test_output_control_b
// - Command byte: read bit, seven address bits
// - Write stores data; read shifts register out
// - Address increments until low bits 0x1F
// - Reset clears registers, 0x08 resets to 0x08
package dip_pkg;
  localparam int unsigned SAMPLE_WIDTH = 16;
  localparam int unsigned REG_COUNT = 32;
  localparam int unsigned ADDR_WIDTH = 7;
  localparam logic [6:0] ADDR_CLOCK_OUTPUT_CONFIG = 7'h02;
  localparam logic [6:0] ADDR_PORT_MODE = 7'h03;
  localparam logic [6:0] ADDR_SPECIAL = 7'h08;
  localparam logic [6:0] ADDR_TEST_OUTPUT_CONTROL_A = 7'h18;
  localparam logic [6:0] ADDR_TEST_OUTPUT_CONTROL_B = 7'h19;
  localparam logic [4:0] ADDR_LOW_LAST = 5'h1f;
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;
  localparam logic [7:0] REG_SPECIAL_RESET = 8'h08;
  localparam int unsigned BIT_RATE_SEL = 0;
  localparam int unsigned BIT_DRIVE_HIGH = 1;
  localparam int unsigned BIT_TERM_EN = 2;
  localparam int unsigned BIT_DUAL_PORT = 0;
  localparam int unsigned BIT_TEST_ENABLE = 0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] TEST_SEL_DATA_CLOCK = 2'h0;
  localparam logic [1:0] TEST_SEL_SAMPLE_STROBE = 2'h1;
  localparam logic [1:0] TEST_SEL_POWER_STATE = 2'h2;
  localparam logic [15:0] CODE_MIDSCALE = 16'h0000;
  localparam logic [15:0] CODE_SIGN_FLIP = 16'h8000;
  localparam logic [1:0] DIV_QUARTER_TOGGLE = 2'h1;
  typedef enum logic [1:0] {PH_COMMAND, PH_DATA} dip_phase_type;
endpackage : dip_pkg

// File: rtl/dip_top.sv
// DAC input ports, sample interleaver, divided clock and serial register port
`timescale 1ns/1ps
module dip_top #(
  parameter int unsigned SAMPLE_WIDTH = dip_pkg::SAMPLE_WIDTH
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic serial_select_n,
  input wire logic serial_clock,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_out_oe,
  input wire logic power_down_n,
  input wire logic input_data_clock,
  input wire logic [SAMPLE_WIDTH-1:0] port_a_data,
  input wire logic [SAMPLE_WIDTH-1:0] port_b_data,
  output logic signed [SAMPLE_WIDTH-1:0] dac_code,
  output logic [SAMPLE_WIDTH-1:0] analog_current_output,
  output logic sample_strobe,
  output logic divided_clock_out,
  output logic divided_clock_drive_high,
  output logic divided_clock_term_en,
  output logic test_output,
  output logic powered_down
);
  localparam int unsigned SW = SAMPLE_WIDTH;

  // Two-stage synchronisers plus one history stage for edge detection
  logic [2:0] cs_s_q, sck_s_q, dck_s_q;
  logic [1:0] sdi_s_q, pd_s_q;
  logic [SW-1:0] pa_s1_q, pa_s2_q, pb_s1_q, pb_s2_q;
  always_ff @(posedge clk_sys) begin
    cs_s_q <= {cs_s_q[1:0], serial_select_n};
    sck_s_q <= {sck_s_q[1:0], serial_clock};
    dck_s_q <= {dck_s_q[1:0], input_data_clock};
    sdi_s_q <= {sdi_s_q[0], serial_data_in};
    pd_s_q <= {pd_s_q[0], power_down_n};
    pa_s1_q <= port_a_data;
    pa_s2_q <= pa_s1_q;
    pb_s1_q <= port_b_data;
    pb_s2_q <= pb_s1_q;
  end

  logic cs_n, sck_rise, sck_fall, dck_edge;
  assign cs_n = cs_s_q[1];
  assign sck_rise = sck_s_q[1] & ~sck_s_q[2] & ~cs_n;
  assign sck_fall = ~sck_s_q[1] & sck_s_q[2] & ~cs_n;
  assign dck_edge = dck_s_q[1] ^ dck_s_q[2];

  // Serial register port
  logic [7:0] regs_q [dip_pkg::REG_COUNT];
  logic [7:0] regs_d [dip_pkg::REG_COUNT];
  dip_pkg::dip_phase_type phase_q, phase_d;
  logic [2:0] bit_cnt_q, bit_cnt_d;
  logic [6:0] shift_in_q, shift_in_d;
  logic [7:0] shift_out_q, shift_out_d;
  logic [6:0] addr_q, addr_d;
  logic read_q, read_d;
  logic sdo_q, sdo_d, sdo_oe_q, sdo_oe_d;

  // Addresses beyond the array read zero and drop writes
  function automatic logic [7:0] reg_read(input logic [6:0] a,
                                          input logic [7:0] r [dip_pkg::REG_COUNT]);
    if (a < 7'(dip_pkg::REG_COUNT)) begin
      reg_read = r[a[4:0]];
    end else begin
      reg_read = dip_pkg::REG_RESET_VALUE;
    end
  endfunction : reg_read

  always_comb begin
    logic [7:0] byte_in;
    logic [6:0] next_addr;
    byte_in = {shift_in_q, sdi_s_q[1]};
    next_addr = addr_q;
    regs_d = regs_q;
    phase_d = phase_q;
    bit_cnt_d = bit_cnt_q;
    shift_in_d = shift_in_q;
    shift_out_d = shift_out_q;
    addr_d = addr_q;
    read_d = read_q;
    sdo_d = sdo_q;
    sdo_oe_d = ~cs_n;
    if (cs_n) begin
      phase_d = dip_pkg::PH_COMMAND;
      bit_cnt_d = '0;
      sdo_d = 1'b0;
    end else if (sck_rise) begin
      shift_in_d = byte_in[6:0];
      bit_cnt_d = bit_cnt_q + 3'h1;
      if (bit_cnt_q == dip_pkg::BIT_LAST) begin
        if (phase_q == dip_pkg::PH_COMMAND) begin
          read_d = byte_in[7];
          addr_d = byte_in[6:0];
          phase_d = dip_pkg::PH_DATA;
          shift_out_d = reg_read(byte_in[6:0], regs_q);
        end else begin
          if (!read_q && addr_q < 7'(dip_pkg::REG_COUNT)) begin
            regs_d[addr_q[4:0]] = byte_in;
          end
          if (addr_q[4:0] != dip_pkg::ADDR_LOW_LAST) begin
            next_addr = addr_q + 7'h01;
          end
          addr_d = next_addr;
          shift_out_d = reg_read(next_addr, regs_q);
        end
      end
    end else if (sck_fall) begin
      if (read_q && phase_q == dip_pkg::PH_DATA) begin
        sdo_d = shift_out_q[7];
        shift_out_d = {shift_out_q[6:0], 1'b0};
      end else begin
        sdo_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int i = 0; i < int'(dip_pkg::REG_COUNT); i++) begin
        regs_q[i] <= dip_pkg::REG_RESET_VALUE;
      end
      regs_q[dip_pkg::ADDR_SPECIAL[4:0]] <= dip_pkg::REG_SPECIAL_RESET;
      phase_q <= dip_pkg::PH_COMMAND;
      bit_cnt_q <= '0;
      shift_in_q <= '0;
      shift_out_q <= '0;
      addr_q <= '0;
      read_q <= 1'b0;
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else begin
      regs_q <= regs_d;
      phase_q <= phase_d;
      bit_cnt_q <= bit_cnt_d;
      shift_in_q <= shift_in_d;
      shift_out_q <= shift_out_d;
      addr_q <= addr_d;
      read_q <= read_d;
      sdo_q <= sdo_d;
      sdo_oe_q <= sdo_oe_d;
    end
  end

  // Sample path: clk_sys stands in for the sample clock
  logic [7:0] clk_cfg, port_mode, test_a, test_b;
  assign clk_cfg = regs_q[dip_pkg::ADDR_CLOCK_OUTPUT_CONFIG[4:0]];
  assign port_mode = regs_q[dip_pkg::ADDR_PORT_MODE[4:0]];
  assign test_a = regs_q[dip_pkg::ADDR_TEST_OUTPUT_CONTROL_A[4:0]];
  assign test_b = regs_q[dip_pkg::ADDR_TEST_OUTPUT_CONTROL_B[4:0]];

  logic dual_mode, pd_active;
  assign dual_mode = port_mode[dip_pkg::BIT_DUAL_PORT];
  assign pd_active = ~pd_s_q[1];

  logic signed [SW-1:0] code_q, code_d, held_b_q, held_b_d;
  logic pend_b_q, pend_b_d, strobe_q, strobe_d;
  logic [1:0] div_cnt_q, div_cnt_d;
  logic dck_out_q, dck_out_d, test_q, test_d;

  always_comb begin
    code_d = code_q;
    held_b_d = held_b_q;
    pend_b_d = 1'b0;
    strobe_d = 1'b0;
    div_cnt_d = div_cnt_q + 2'h1;
    dck_out_d = dck_out_q;
    if (pd_active) begin
      code_d = dip_pkg::CODE_MIDSCALE;
      div_cnt_d = '0;
      dck_out_d = 1'b0;
    end else begin
      if (dck_edge) begin
        strobe_d = 1'b1;
        if (dual_mode) begin
          code_d = $signed(pa_s2_q);
          held_b_d = $signed(pb_s2_q);
          pend_b_d = 1'b1;
        end else begin
          code_d = $signed(pb_s2_q);
        end
      end else if (pend_b_q) begin
        code_d = held_b_q;
        strobe_d = 1'b1;
      end
      // Divided output toggles every cycle for half rate, every second for quarter
      if (clk_cfg[dip_pkg::BIT_RATE_SEL] || div_cnt_q[0] == dip_pkg::DIV_QUARTER_TOGGLE[0]) begin
        dck_out_d = ~dck_out_q;
      end
    end
    // Timing is simplified to a digital monitor of the selected source
    case (test_b[1:0])
      dip_pkg::TEST_SEL_DATA_CLOCK: test_d = dck_s_q[1];
      dip_pkg::TEST_SEL_SAMPLE_STROBE: test_d = strobe_q;
      dip_pkg::TEST_SEL_POWER_STATE: test_d = pd_active;
      default: test_d = 1'b0;
    endcase
    test_d = test_d & test_a[dip_pkg::BIT_TEST_ENABLE];
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      code_q <= dip_pkg::CODE_MIDSCALE;
      held_b_q <= dip_pkg::CODE_MIDSCALE;
      pend_b_q <= 1'b0;
      strobe_q <= 1'b0;
      div_cnt_q <= '0;
      dck_out_q <= 1'b0;
      test_q <= 1'b0;
    end else begin
      code_q <= code_d;
      held_b_q <= held_b_d;
      pend_b_q <= pend_b_d;
      strobe_q <= strobe_d;
      div_cnt_q <= div_cnt_d;
      dck_out_q <= dck_out_d;
      test_q <= test_d;
    end
  end

  // Output stage registers; offset code puts zero at half of full scale
  logic [SW-1:0] level_q;
  logic drive_q, term_q, pd_q;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      level_q <= dip_pkg::CODE_SIGN_FLIP;
      drive_q <= 1'b0;
      term_q <= 1'b0;
      pd_q <= 1'b0;
    end else begin
      level_q <= code_d ^ dip_pkg::CODE_SIGN_FLIP;
      drive_q <= clk_cfg[dip_pkg::BIT_DRIVE_HIGH];
      term_q <= clk_cfg[dip_pkg::BIT_TERM_EN];
      pd_q <= pd_active;
    end
  end

  assign serial_data_out = sdo_q;
  assign serial_data_out_oe = sdo_oe_q;
  assign dac_code = code_q;
  assign analog_current_output = level_q;
  assign sample_strobe = strobe_q;
  assign divided_clock_out = dck_out_q;
  assign divided_clock_drive_high = drive_q;
  assign divided_clock_term_en = term_q;
  assign test_output = test_q;
  assign powered_down = pd_q;
endmodule : dip_top

// File: verif/dip_props.sv
// Concurrent checks on the serial port and sample path
`timescale 1ns/1ps
module dip_props #(parameter int unsigned SAMPLE_WIDTH = 16) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic serial_select_n,
  input wire logic serial_clock,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe,
  input wire logic power_down_n,
  input wire logic signed [SAMPLE_WIDTH-1:0] dac_code,
  input wire logic [SAMPLE_WIDTH-1:0] analog_current_output,
  input wire logic sample_strobe,
  input wire logic divided_clock_out,
  input wire logic powered_down
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Pin synchronisers add up to three cycles, so the select checks wait five and the power-down pin checks six
  property p_oe_on; !serial_select_n [*5] |-> serial_data_out_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("sdo not driven");
  property p_oe_off; serial_select_n [*5] |-> !serial_data_out_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("sdo not released");
  property p_sdo_edge; $changed(serial_data_out) |-> !serial_clock; endproperty
  a_sdo_edge: assert property (p_sdo_edge) else $error("sdo moved on high clock");
  property p_mid; analog_current_output == (dac_code ^ dip_pkg::CODE_SIGN_FLIP); endproperty
  a_mid: assert property (p_mid) else $error("level not offset code");
  property p_pair; sample_strobe ##1 sample_strobe |=> !sample_strobe; endproperty
  a_pair: assert property (p_pair) else $error("strobe run too long");
  property p_pd_code; powered_down |-> dac_code == dip_pkg::CODE_MIDSCALE && !sample_strobe;
  endproperty
  a_pd_code: assert property (p_pd_code) else $error("code live in power down");
  property p_pd_clk; powered_down [*2] |-> !divided_clock_out; endproperty
  a_pd_clk: assert property (p_pd_clk) else $error("clock out runs in power down");
  property p_pd_in; !power_down_n [*6] |-> powered_down; endproperty
  a_pd_in: assert property (p_pd_in) else $error("power down not entered");
  property p_pd_out; power_down_n [*6] |-> !powered_down; endproperty
  a_pd_out: assert property (p_pd_out) else $error("power down not left");
endmodule : dip_props
bind dip_top dip_props #(.SAMPLE_WIDTH(SAMPLE_WIDTH)) u_props (.clk_sys(clk_sys),
  .reset(reset), .serial_select_n(serial_select_n), .serial_clock(serial_clock),
  .serial_data_out(serial_data_out), .serial_data_out_oe(serial_data_out_oe),
  .power_down_n(power_down_n), .dac_code(dac_code), .sample_strobe(sample_strobe),
  .analog_current_output(analog_current_output), .divided_clock_out(divided_clock_out),
  .powered_down(powered_down));

// File: verif/dip_host_model.sv
// Host model driving the serial register port
`timescale 1ns/1ps
module dip_host_model (
  input wire logic clk_sys,
  output logic serial_select_n,
  output logic serial_clock,
  output logic serial_data_in,
  input wire logic serial_data_out
);
  initial begin
    serial_select_n = 1'b1;
    serial_clock = 1'b0;
    serial_data_in = 1'b0;
  end
  // One frame of n bytes; the clock stands low outside frames
  task automatic frame(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = 32'h0000_0000;
    serial_select_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    for (int k = 0; k < n * 8; k++) begin
      serial_data_in = tx[31-k];
      repeat (8) @(negedge clk_sys);
      serial_clock = 1'b1;
      rx[31-k] = serial_data_out;
      repeat (8) @(negedge clk_sys);
      serial_clock = 1'b0;
    end
    serial_select_n = 1'b1;
    serial_data_in = ~serial_data_in;
    repeat (8) @(negedge clk_sys);
  endtask : frame
endmodule : dip_host_model

// File: verif/dip_top_test.sv
// Testbench for the DAC input port and serial control block
`timescale 1ns/1ps
module dip_top_test;
  logic clk_sys, reset, serial_select_n, serial_clock, serial_data_in, serial_data_out;
  logic serial_data_out_oe, power_down_n, input_data_clock, sample_strobe, test_output;
  logic divided_clock_out, divided_clock_drive_high, divided_clock_term_en, powered_down;
  logic [15:0] port_a_data, port_b_data, analog_current_output;
  logic signed [15:0] dac_code;
  logic [31:0] rx;
  // Set once the test output is steered to the sample strobe
  logic mon_strobe;
  logic [6:0] alist [5] = '{7'h02, 7'h03, 7'h08, 7'h18, 7'h19};
  int fails, samples_checked;
  // Released data line is pulled up
  wire logic sdo_line = serial_data_out_oe ? serial_data_out : 1'b1;
  dip_top dut (.clk_sys(clk_sys), .reset(reset), .serial_select_n(serial_select_n),
    .serial_clock(serial_clock), .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out), .serial_data_out_oe(serial_data_out_oe),
    .power_down_n(power_down_n), .input_data_clock(input_data_clock),
    .port_a_data(port_a_data), .port_b_data(port_b_data), .dac_code(dac_code),
    .analog_current_output(analog_current_output), .sample_strobe(sample_strobe),
    .divided_clock_out(divided_clock_out), .divided_clock_drive_high(divided_clock_drive_high),
    .divided_clock_term_en(divided_clock_term_en), .test_output(test_output),
    .powered_down(powered_down));
  dip_host_model host (.clk_sys(clk_sys), .serial_select_n(serial_select_n),
    .serial_clock(serial_clock), .serial_data_in(serial_data_in), .serial_data_out(sdo_line));
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.frame({1'b0, a, d, 16'h0000}, 2, rx);
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    host.frame({1'b1, a, 24'h00_0000}, 2, rx);
    check("register", {16'h0000, rx[23:16]}, {16'h0000, e});
  endtask : rd
  task automatic div_rate(input int e);
    int n;
    logic v;
    n = 0;
    for (int k = 0; k < 8; k++) begin
      v = divided_clock_out;
      @(negedge clk_sys);
      if (divided_clock_out !== v) n++;
    end
    check("clock out toggles", 24'(n), 24'(e));
  endtask : div_rate
  // Data clock toggles at least four cycles apart, well under the dual limit
  task automatic send(input logic [15:0] a, input logic [15:0] b, input logic dual);
    int n;
    port_a_data = a;
    port_b_data = b;
    repeat (4) @(negedge clk_sys);
    input_data_clock = ~input_data_clock;
    n = 0;
    while (sample_strobe !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 20) begin
      fails++;
      end_sim();
    end
    check("code", {8'h00, dac_code}, dual ? a : b);
    check("level", analog_current_output, (dual ? a : b) ^ dip_pkg::CODE_SIGN_FLIP);
    @(negedge clk_sys);
    if (dual) check("second code", {8'h00, dac_code}, b);
    if (mon_strobe) check("test strobe", test_output, 1'b1);
    repeat (4) @(negedge clk_sys);
  endtask : send
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    reset = 1'b1;
    power_down_n = 1'b1;
    input_data_clock = 1'b0;
    port_a_data = 16'h0000;
    port_b_data = 16'h0000;
    fails = 0;
    samples_checked = 0;
    mon_strobe = 1'b0;
    repeat (10) @(negedge clk_sys);
    reset = 1'b0;
    repeat (4) @(negedge clk_sys);
    foreach (alist[i]) rd(alist[i], alist[i] == dip_pkg::ADDR_SPECIAL ? 8'h08 : 8'h00);
    $display("test reset values done");
    wr(dip_pkg::ADDR_CLOCK_OUTPUT_CONFIG, 8'h06);
    check("drive term", {divided_clock_drive_high, divided_clock_term_en}, 2'b11);
    div_rate(4);
    wr(dip_pkg::ADDR_CLOCK_OUTPUT_CONFIG, 8'h01);
    check("drive term", {divided_clock_drive_high, divided_clock_term_en}, 2'b00);
    div_rate(8);
    rd(dip_pkg::ADDR_CLOCK_OUTPUT_CONFIG, 8'h01);
    check("oe idle", serial_data_out_oe, 1'b0);
    $display("test clock out done");
    host.frame({1'b0, 7'h1e, 8'h11, 8'h22, 8'h33}, 4, rx);
    check("write sdo", rx[23:0], 24'h00_0000);
    host.frame({1'b1, 7'h1e, 24'h00_0000}, 4, rx);
    check("burst", rx[23:0], 24'h11_3333);
    wr(7'h20, 8'h5a);
    rd(7'h20, 8'h00);
    $display("test burst done");
    send(16'h8001, 16'h7ffe, 1'b0);
    wr(dip_pkg::ADDR_PORT_MODE, 8'h01);
    send(16'h1234, 16'hfedc, 1'b1);
    send(16'h0000, 16'h0000, 1'b1);
    $display("test samples done");
    wr(dip_pkg::ADDR_TEST_OUTPUT_CONTROL_B, 8'h02);
    power_down_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    check("test gated", test_output, 1'b0);
    wr(dip_pkg::ADDR_TEST_OUTPUT_CONTROL_A, 8'h01);
    check("power state", {powered_down, test_output}, 2'b11);
    check("pd code", {8'h00, dac_code}, 24'h00_0000);
    wr(dip_pkg::ADDR_TEST_OUTPUT_CONTROL_B, 8'h03);
    check("test zero", test_output, 1'b0);
    power_down_n = 1'b1;
    wr(dip_pkg::ADDR_TEST_OUTPUT_CONTROL_B, 8'h00);
    check("test data clock", test_output, input_data_clock);
    check("awake", powered_down, 1'b0);
    wr(dip_pkg::ADDR_TEST_OUTPUT_CONTROL_B, 8'h01);
    mon_strobe = 1'b1;
    send(16'h0101, 16'h0202, 1'b1);
    $display("test power done");
    end_sim();
  end
endmodule : dip_top_test
